// ### bench/pif_periph.sv
// Behavioural peripheral side: event sources and receive data
`timescale 1ns/100ps
module pif_periph
#(
    parameter logic [7:0] RX_VAL = 8'h5A
)
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire pif_pkg::pif_events_type req,
    output pif_pkg::pif_events_type      events,
    output logic [7:0]                   rx_byte
);
    // ****************
    // Event sources
    // ****************
    logic [7:0] cnt_q;
    // Events leave a flop, as a peripheral on the same clock drives them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            events <= '0;
            cnt_q  <= 8'h00;
        end
        else
        begin
            events <= req;
            cnt_q  <= cnt_q + 8'h01;
        end
    end
    // Data holds only while the buffer is full; otherwise it churns every cycle
    assign rx_byte = events.rx_full ? RX_VAL : cnt_q;
endmodule

// ### bench/pif_top_bench.sv
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/100ps
`include "pif_defs.svh"
module pif_top_bench;
    localparam logic [7:0] RXV = 8'h5A;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                      tx_load, core_irq_req, irq, rerr;
    logic [11:0]               paddr;
    logic [3:0]                pstrb;
    logic [31:0]               pwdata, prdata, rdat;
    logic [7:0]                rx_byte, tx_byte;
    pif_pkg::pif_events_type   req, events;
    pif_pkg::pif_ccp_mode_type ccp_mode;
    int                        err_count, comparisons;

    pif_top dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .ccp_mode(ccp_mode), .rx_byte(rx_byte),
        .tx_byte(tx_byte), .tx_load(tx_load), .core_irq_req(core_irq_req), .irq(irq)
    );
    pif_periph #(.RX_VAL(RXV)) peer
    (
        .pclk(pclk), .presetn(presetn), .req(req), .events(events), .rx_byte(rx_byte)
    );

    // ****************
    // Helpers
    // ****************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held from setup until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Values read right after the edge are those the slave presented at it
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
            test_done();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdat);
    endtask
    task automatic pulse(input int b);
        @(posedge pclk);
        req[b] <= 1'b1;
        @(posedge pclk);
        req[b] <= 1'b0;
        idle(3);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
            if (i != 4 && i != 5)
                rd(12'(4 * i), "reset value", (i == 3) ? 32'h0000_0080 : 32'h0000_0000);
        xfer(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
        wr(`PIF_OFF_OPTION, 32'h0000_00A5);
        rd(`PIF_OFF_OPTION, "option", 32'h0000_00A5);
        pstrb <= 4'h0;
        wr(`PIF_OFF_OPTION, 32'h0000_00FF);
        pstrb <= 4'hF;
        rd(`PIF_OFF_OPTION, "option no strobe", 32'h0000_00A5);
        xfer(1'b1, 12'h024, 32'h0000_00FF);
        chk("unmapped write error", 32'h0000_0001, {31'h0, rerr});
        wr(`PIF_OFF_CORE_CTRL, 32'h0000_003F);
        rd(`PIF_OFF_CORE_CTRL, "control mask", 32'h0000_0038);
        req.gate_active <= 1'b1;
        idle(4);
        rd(`PIF_OFF_PER_FLAGS, "gate active", 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic t_sticky();
        int s[4] = '{7, 4, 1, 0};
        int f[4] = '{6, 3, 1, 0};
        for (int i = 0; i < 4; i++)
        begin
            pulse(s[i]);
            rd(`PIF_OFF_PER_FLAGS, "flag set", 32'h1 << f[i]);
            chk("no request", 32'h0000_0000, {31'h0, core_irq_req});
            wr(`PIF_OFF_PER_FLAGS, 32'h0000_0000);
            rd(`PIF_OFF_PER_FLAGS, "flag clear", 32'h0000_0000);
        end
        $display("sticky test done");
    endtask
    task automatic t_ccp();
        for (int m = 0; m < 4; m++)
        begin
            ccp_mode <= pif_pkg::pif_ccp_mode_type'(m);
            pulse(3);
            rd(`PIF_OFF_PER_FLAGS, "capture", (m == 0) ? 32'h0000_0004 : 32'h0000_0000);
            pulse(2);
            rd(`PIF_OFF_PER_FLAGS, "compare", (m < 2) ? 32'h0000_0004 : 32'h0000_0000);
            wr(`PIF_OFF_PER_FLAGS, 32'h0000_0000);
        end
        $display("ccp test done");
    endtask
    task automatic t_serial();
        req.rx_full <= 1'b1;
        idle(4);
        rd(`PIF_OFF_PER_FLAGS, "rx full", 32'h0000_0020);
        wr(`PIF_OFF_PER_FLAGS, 32'h0000_0000);
        rd(`PIF_OFF_PER_FLAGS, "rx read only", 32'h0000_0020);
        req.rx_full <= 1'b0;
        idle(3);
        req.rx_full <= 1'b1;
        idle(4);
        rd(`PIF_OFF_IRQ_STATUS, "rx overrun", 32'h0000_0002);
        wr(`PIF_OFF_IRQ_STATUS, 32'h0000_0002);
        rd(`PIF_OFF_IRQ_STATUS, "overrun cleared", 32'h0000_0000);
        rd(`PIF_OFF_RX_DATA, "rx data", {24'h0, RXV});
        rd(`PIF_OFF_PER_FLAGS, "rx cleared", 32'h0000_0000);
        req.rx_full <= 1'b0;
        req.tx_empty <= 1'b1;
        idle(4);
        rd(`PIF_OFF_PER_FLAGS, "tx empty", 32'h0000_0010);
        req.tx_empty <= 1'b0;
        wr(`PIF_OFF_TX_DATA, 32'h0000_003C);
        rd(`PIF_OFF_PER_FLAGS, "tx full", 32'h0000_0000);
        chk("tx byte", 32'h0000_003C, {24'h0, tx_byte});
        $display("serial test done");
    endtask
    task automatic t_gate();
        pulse(0);
        wr(`PIF_OFF_PER_ENABLE, 32'h0000_0002);
        wr(`PIF_OFF_CORE_CTRL, 32'h0000_00C0);
        idle(3);
        chk("other enable", 32'h0000_0000, {31'h0, core_irq_req});
        wr(`PIF_OFF_PER_ENABLE, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
        begin
            wr(`PIF_OFF_CORE_CTRL, 32'(i) << 6);
            idle(3);
            chk("gated request", {31'h0, i == 3}, {31'h0, core_irq_req});
        end
        chk("masked irq", 32'h0000_0000, {31'h0, irq});
        wr(`PIF_OFF_IRQ_MASK, 32'h0000_0001);
        idle(2);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rd(`PIF_OFF_IRQ_STATUS, "status", 32'h0000_0001);
        wr(`PIF_OFF_IRQ_STATUS, 32'h0000_0001);
        idle(2);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        wr(`PIF_OFF_PER_FLAGS, 32'h0000_0000);
        idle(3);
        chk("request dropped", 32'h0000_0000, {31'h0, core_irq_req});
        $display("gating test done");
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pstrb    = 4'hF;
        pwdata   = 32'h0000_0000;
        req      = '0;
        ccp_mode = pif_pkg::PIF_MODE_CAPTURE;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sticky();
        t_ccp();
        t_serial();
        t_gate();
        test_done();
    end
endmodule

// ### bench/pif_top_props.sv
// Concurrent checks on the APB answers and the transmit outputs of the flag block
`timescale 1ns/100ps
`include "pif_defs.svh"
module pif_top_props
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [7:0]        tx_byte,
    input wire logic              tx_load,
    input wire logic              core_irq_req,
    input wire logic              irq
);
    // ****************
    // Properties
    // ****************
    logic wr_tx;
    assign wr_tx = psel && penable && pready && pwrite && pstrb[0] && paddr == `PIF_OFF_TX_DATA;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    AST_READY_LATE: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_READY_CAUSE: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("pslverr without pready or with data");
    AST_UNMAPPED: assert property (pready && paddr >= 12'h020 |-> pslverr)
        else $error("unmapped access not refused");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    AST_TX_LOAD: assert property (wr_tx |=> tx_load && tx_byte == $past(pwdata[7:0]))
        else $error("transmit write not loaded");
    AST_TX_CAUSE: assert property (tx_load |-> $past(wr_tx))
        else $error("transmit load without a write");
    cover property (wr_tx);
    cover property (pslverr);
    cover property ($rose(core_irq_req));
    cover property ($rose(irq));
endmodule

bind pif_top pif_top_props #(.ADDR_W(ADDR_W)) u_props
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_byte(tx_byte), .tx_load(tx_load), .core_irq_req(core_irq_req),
    .irq(irq)
);

// ### verilog/pif_defs.svh
// Register offsets, field positions and reset values of the peripheral interrupt flag block
`ifndef PIF_DEFS_SVH
`define PIF_DEFS_SVH

`define PIF_OFF_CORE_CTRL   12'h000
`define PIF_OFF_OPTION      12'h004
`define PIF_OFF_PER_ENABLE  12'h008
`define PIF_OFF_PER_FLAGS   12'h00C
`define PIF_OFF_RX_DATA     12'h010
`define PIF_OFF_TX_DATA     12'h014
`define PIF_OFF_IRQ_STATUS  12'h018
`define PIF_OFF_IRQ_MASK    12'h01C

`define PIF_BIT_GATE        7
`define PIF_BIT_ADC         6
`define PIF_BIT_RX          5
`define PIF_BIT_TX          4
`define PIF_BIT_SSP         3
`define PIF_BIT_CCP         2
`define PIF_BIT_TMR2        1
`define PIF_BIT_TIMER_ONE_COUNT        0

`define PIF_BIT_GIE         7
`define PIF_BIT_PERIPHERAL_IRQ_ENABLE        6

`define PIF_RESET_BYTE      8'h00
`define PIF_SW_CLR_MASK     8'hCF
`define PIF_CTRL_WR_MASK    8'hF8
`define PIF_STAT_REQ        0
`define PIF_STAT_RXOVR      1
`define PIF_STAT_WIDTH      2

`endif

// ### verilog/pif_pkg.sv
// Types shared by the peripheral interrupt flag block
package pif_pkg;

    typedef enum logic [1:0]
    {
        PIF_MODE_CAPTURE,
        PIF_MODE_COMPARE,
        PIF_MODE_PWM,
        PIF_MODE_OFF
    } pif_ccp_mode_type;

    typedef struct packed
    {
        logic gate_active;
        logic adc_done;
        logic rx_full;
        logic tx_empty;
        logic ssp_done;
        logic ccp_capture;
        logic ccp_match;
        logic tmr2_match;
        logic timer_one_count_ovf;
    } pif_events_type;

endpackage

// ### verilog/pif_top.sv
// Peripheral interrupt flag register, enables and request gating behind APB
`timescale 1ns/100ps
`include "pif_defs.svh"

module pif_top
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire pif_pkg::pif_events_type   events,
    input  wire pif_pkg::pif_ccp_mode_type ccp_mode,
    input  wire logic [7:0]                rx_byte,
    output logic      [7:0]                tx_byte,
    output logic                           tx_load,
    output logic                           core_irq_req,
    output logic                           irq
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic access_w;
    logic wr_w;
    logic rd_w;
    logic hit_w;
    logic low_lane_w;

    // Writes and read side effects commit on the edge that completes the access
    assign access_w   = psel && penable && pready;
    assign wr_w       = access_w && pwrite;
    assign rd_w       = access_w && !pwrite;
    assign low_lane_w = pstrb[0];
    // Full-offset decode: any other offset is refused
    assign hit_w      = (paddr == `PIF_OFF_CORE_CTRL)  || (paddr == `PIF_OFF_OPTION)
                     || (paddr == `PIF_OFF_PER_ENABLE) || (paddr == `PIF_OFF_PER_FLAGS)
                     || (paddr == `PIF_OFF_RX_DATA)    || (paddr == `PIF_OFF_TX_DATA)
                     || (paddr == `PIF_OFF_IRQ_STATUS) || (paddr == `PIF_OFF_IRQ_MASK);

    logic wr_ctrl_w;
    logic wr_opt_w;
    logic wr_en_w;
    logic wr_flag_w;
    logic wr_tx_w;
    logic wr_stat_w;
    logic wr_mask_w;
    logic rd_rx_w;

    assign wr_ctrl_w = wr_w && low_lane_w && (paddr == `PIF_OFF_CORE_CTRL);
    assign wr_opt_w  = wr_w && low_lane_w && (paddr == `PIF_OFF_OPTION);
    assign wr_en_w   = wr_w && low_lane_w && (paddr == `PIF_OFF_PER_ENABLE);
    assign wr_flag_w = wr_w && low_lane_w && (paddr == `PIF_OFF_PER_FLAGS);
    assign wr_tx_w   = wr_w && low_lane_w && (paddr == `PIF_OFF_TX_DATA);
    assign wr_stat_w = wr_w && low_lane_w && (paddr == `PIF_OFF_IRQ_STATUS);
    assign wr_mask_w = wr_w && low_lane_w && (paddr == `PIF_OFF_IRQ_MASK);
    assign rd_rx_w   = rd_w && (paddr == `PIF_OFF_RX_DATA);

    // ************************************************************
    // Event inputs
    // ************************************************************
    // Events come from peripheral logic on pclk, so no synchroniser is needed
    pif_pkg::pif_events_type ev_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_q <= '0;
        else
            ev_q <= events;
    end

    logic ccp_set_w;

    // Pulse-width and off modes never set the flag
    always_comb
    begin
        case (ccp_mode)
            pif_pkg::PIF_MODE_CAPTURE: ccp_set_w = ev_q.ccp_capture;
            pif_pkg::PIF_MODE_COMPARE: ccp_set_w = ev_q.ccp_match;
            default:                   ccp_set_w = 1'b0;
        endcase
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    logic [7:0] core_ctrl_q;
    logic [7:0] option_q;
    logic [7:0] per_enable_q;

    // Low three bits stay zero: those sources live outside this block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_ctrl_q <= `PIF_RESET_BYTE;
        else if (wr_ctrl_w)
            core_ctrl_q <= pwdata[7:0] & `PIF_CTRL_WR_MASK;
    end

    // Option bits are storage only; they steer logic outside this block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            option_q <= `PIF_RESET_BYTE;
        else if (wr_opt_w)
            option_q <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            per_enable_q <= `PIF_RESET_BYTE;
        else if (wr_en_w)
            per_enable_q <= pwdata[7:0];
    end

    // ************************************************************
    // Flag register
    // ************************************************************
    logic [7:0] set_w;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic       rx_full_q;
    logic       tx_empty_q;

    // Sticky sources only; the read-only bits are filled in below
    always_comb
    begin
        set_w                 = '0;
        set_w[`PIF_BIT_ADC]   = ev_q.adc_done;
        set_w[`PIF_BIT_SSP]   = ev_q.ssp_done;
        set_w[`PIF_BIT_CCP]   = ccp_set_w;
        set_w[`PIF_BIT_TMR2]  = ev_q.tmr2_match;
        set_w[`PIF_BIT_TIMER_ONE_COUNT]  = ev_q.timer_one_count_ovf;
    end

    // Writes may clear or set the sticky bits; a hardware set always wins
    always_comb
    begin
        flags_d = flags_q;
        if (wr_flag_w)
            flags_d = (flags_q & ~`PIF_SW_CLR_MASK) | (pwdata[7:0] & `PIF_SW_CLR_MASK);
        flags_d = flags_d | set_w;
        // Read-only bits follow their sources and ignore software writes
        flags_d[`PIF_BIT_GATE] = !ev_q.gate_active;
        flags_d[`PIF_BIT_RX]   = rx_full_q;
        flags_d[`PIF_BIT_TX]   = tx_empty_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= `PIF_RESET_BYTE;
        else
            flags_q <= flags_d;
    end

    // ************************************************************
    // Serial buffer status
    // ************************************************************
    logic rx_seen_q;
    logic rx_rise_w;

    // Peripheral reports a new byte on the rising edge of rx_full
    assign rx_rise_w = ev_q.rx_full && !rx_seen_q;

    // Starts low to match the idle level of rx_full, so reset makes no false edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_seen_q <= 1'b0;
        else
            rx_seen_q <= ev_q.rx_full;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_full_q <= 1'b0;
        else if (rx_rise_w)
            rx_full_q <= 1'b1;
        else if (rd_rx_w)
            rx_full_q <= 1'b0;
    end

    // Buffer empties when the serializer takes the byte; a write refills it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_empty_q <= 1'b0;
        else if (wr_tx_w)
            tx_empty_q <= 1'b0;
        else if (ev_q.tx_empty)
            tx_empty_q <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_byte <= `PIF_RESET_BYTE;
        else if (wr_tx_w)
            tx_byte <= pwdata[7:0];
    end

    // One-cycle strobe tells the serializer that a new byte waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_load <= 1'b0;
        else
            tx_load <= wr_tx_w;
    end

    // ************************************************************
    // Request gating
    // ************************************************************
    // Registered so the core sees a clean level, one cycle after the flags
    logic req_w;

    assign req_w = (|(flags_q & per_enable_q))
                && core_ctrl_q[`PIF_BIT_PERIPHERAL_IRQ_ENABLE]
                && core_ctrl_q[`PIF_BIT_GIE];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_irq_req <= 1'b0;
        else
            core_irq_req <= req_w;
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    // Status bit 0 marks each new rise of the gated request, bit 1 a receive overrun
    logic [`PIF_STAT_WIDTH-1:0] stat_q;
    logic [`PIF_STAT_WIDTH-1:0] mask_q;
    logic [`PIF_STAT_WIDTH-1:0] stat_set_w;
    logic                       req_seen_q;
    logic [`PIF_STAT_WIDTH-1:0] stat_d;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_seen_q <= 1'b0;
        else
            req_seen_q <= req_w;
    end

    always_comb
    begin
        stat_set_w                  = '0;
        stat_set_w[`PIF_STAT_REQ]   = req_w && !req_seen_q;
        stat_set_w[`PIF_STAT_RXOVR] = rx_rise_w && rx_full_q;
        stat_d = stat_q;
        if (wr_stat_w)
            stat_d = stat_q & ~pwdata[`PIF_STAT_WIDTH-1:0];
        stat_d = stat_d | stat_set_w;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= '0;
        else
            stat_q <= stat_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= '0;
        else if (wr_mask_w)
            mask_q <= pwdata[`PIF_STAT_WIDTH-1:0];
    end

    // Built from the next status value so irq rises with its status bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(stat_d & mask_q);
    end

    // ************************************************************
    // APB answer
    // ************************************************************
    // One wait state keeps prdata registered without a read path through flops twice
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel && penable && !pready;
    end

    // Refused accesses still complete with pready so the master never hangs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= psel && penable && !pready && !hit_w;
    end

    logic [31:0] rd_mux_w;

    // Write-only and unmapped offsets read as zero
    always_comb
    begin
        rd_mux_w = '0;
        case (paddr)
            `PIF_OFF_CORE_CTRL:  rd_mux_w = {24'h00_0000, core_ctrl_q};
            `PIF_OFF_OPTION:     rd_mux_w = {24'h00_0000, option_q};
            `PIF_OFF_PER_ENABLE: rd_mux_w = {24'h00_0000, per_enable_q};
            `PIF_OFF_PER_FLAGS:  rd_mux_w = {24'h00_0000, flags_q};
            `PIF_OFF_RX_DATA:    rd_mux_w = {24'h00_0000, rx_byte};
            `PIF_OFF_IRQ_STATUS: rd_mux_w = {30'h0000_0000, stat_q};
            `PIF_OFF_IRQ_MASK:   rd_mux_w = {30'h0000_0000, mask_q};
            default:             rd_mux_w = '0;
        endcase
    end

    // Writes return zero so a refused write carries no stale read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && penable && !pready)
            prdata <= pwrite ? 32'h0000_0000 : rd_mux_w;
    end

endmodule
